// ===== shared/tw_pkg.sv
`default_nettype none
// ==================================================================
// constants and types shared by the two-wire host files
package tw_pkg;

  // ================================================================
  // timing, core clock 25 MHz
  localparam int CLK_PERIOD_NS = 40;
  localparam int F_SCL_MAX_KHZ = 100;
  // one bit is four quarters of 2.5 us, 10 us per bit
  localparam int T_QUARTER_NS = 2500;
  localparam int QUARTER_CYC = (T_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // least bus free time between stop and next start
  localparam int T_BUF_NS = 4700;
  localparam int FREE_QUARTERS = (T_BUF_NS + T_QUARTER_NS - 1) / T_QUARTER_NS;

  // ================================================================
  // addressing
  localparam logic [6:0] DEV_ADDR = 7'h74;
  localparam logic DIR_WRITE = 1'h0;
  localparam logic DIR_READ = 1'h1;

  // ================================================================
  // phase positions inside a bit or a start/stop condition
  localparam logic [2:0] PH_FIRST = 3'h0;
  localparam logic [2:0] PH_SCL_HIGH = 3'h2;
  localparam logic [2:0] PH_SAMPLE = 3'h2;
  localparam logic [2:0] PH_BIT_LAST = 3'h3;
  localparam logic [2:0] PH_COND_SDA = 3'h4;
  localparam logic [2:0] PH_COND_LAST = 3'h5;
  localparam logic [2:0] PH_FREE_LAST = 3'(FREE_QUARTERS - 1);
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [7:0] RX_FILL = 8'hFF;

  // ================================================================
  // reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic PIN_HIGH_RST = 1'h1;

  // ================================================================
  // bus engine states and transfer segments
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_BIT = 3'b010,
    ST_STOP = 3'b011,
    ST_FREE = 3'b100
  } tw_state_e;

  typedef enum logic [2:0] {
    SEG_ADDR_W = 3'b000,
    SEG_REG = 3'b001,
    SEG_WDATA = 3'b010,
    SEG_ADDR_R = 3'b011,
    SEG_RDATA = 3'b100
  } tw_seg_e;

endpackage : tw_pkg
`default_nettype wire

// ===== hw/tw_sync2.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// two-stage synchroniser for a pin level
module tw_sync2
#(
  parameter logic RST_VAL = 1'h1
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // level in and out
  input wire logic async_i,
  output logic sync_o
);

  logic meta_r;
  logic sync_r;

  // first stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end
    else
    begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule : tw_sync2
`default_nettype wire

// ===== hw/tw_tick.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// divider giving a one-cycle tick every DIV clocks
module tw_tick
#(
  parameter int DIV = 63
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // control and tick
  input wire logic clr_i,
  output logic tick_o
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;
  wire at_last;

  // wrap at the last count, restart while cleared
  assign at_last = (cnt_r == LAST);
  assign cnt_nxt = (clr_i || at_last) ? '0 : cnt_r + 1'b1;
  assign tick_nxt = !clr_i && at_last;

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;

endmodule : tw_tick
`default_nettype wire

// ===== hw/tw_master.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// How it works
// - start is data falling while clock high, made only by us
// - stop is data rising while clock high, ends the transfer
// - data changes only while clock low, one clock pulse per bit
// - we make every clock pulse, acknowledge pulses included
// - bytes are eight bits, msb first, then one acknowledge bit
// - we change data after the falling edge, sample at clock high
// - receiver acknowledges each byte we send by pulling data low
// - on a missing acknowledge we send stop
// - last read byte gets not-acknowledge from us, then stop
// - first byte is seven-bit address plus direction, one is read
// - write: start, address+w, register, data, stop
// - read: start, address+w, register, repeated start, address+r, data
// - idle lines rest high, data line pulled up externally
// ==================================================================
module tw_master
  import tw_pkg::*;
#(
  parameter int QUARTER_CYC_P = QUARTER_CYC
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // command request
  input wire logic cmd_valid_i,
  input wire logic cmd_read_i,
  input wire logic [7:0] cmd_reg_i,
  input wire logic [7:0] cmd_wdata_i,
  // command answer
  output logic cmd_ready_o,
  output logic done_o,
  output logic nack_o,
  output logic fault_o,
  output logic [7:0] rdata_o,
  // two-wire pins
  output logic scl_o,
  input wire logic slave_data_line_i,
  output logic slave_data_line_o,
  output logic slave_data_line_oe_o
);

  // ================================================================
  // state
  tw_state_e state_r;
  tw_state_e state_nxt;
  tw_seg_e seg_r;
  tw_seg_e seg_nxt;
  logic [2:0] phase_r;
  logic [2:0] phase_nxt;
  logic [3:0] bitcnt_r;
  logic [3:0] bitcnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic rw_r;
  logic rw_nxt;
  logic [7:0] reg_r;
  logic [7:0] reg_nxt;
  logic [7:0] wdata_r;
  logic [7:0] wdata_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic nack_r;
  logic nack_nxt;
  logic fault_r;
  logic fault_nxt;
  logic sample_r;
  logic sample_nxt;
  logic done_r;
  logic done_nxt;
  logic ready_r;
  logic ready_nxt;
  logic scl_r;
  logic scl_nxt;
  logic sda_oe_r;
  logic sda_oe_nxt;
  logic sda_lvl_r;

  // ================================================================
  // decoding
  wire tick_w;
  wire sda_s;
  wire idle_w;
  wire is_tx;
  wire data_bit;
  wire drive_low_w;
  wire line_moved;
  wire byte_abort;
  wire lines_free;

  assign idle_w = (state_r == ST_IDLE);
  // only the read data byte is received by us
  assign is_tx = (seg_r != SEG_RDATA);
  assign data_bit = (bitcnt_r != ACK_BIT);
  // open drain: pull low for a zero, release for a one and for our nack
  assign drive_low_w = is_tx && data_bit && !shift_r[7];
  // data moving while clock high breaks the bit
  assign line_moved = (sda_s != sample_r);
  assign byte_abort = nack_r || fault_r || line_moved;
  assign lines_free = (state_nxt == ST_IDLE) || (state_nxt == ST_FREE);

  // ================================================================
  // quarter-bit timebase, held at zero while idle
  tw_tick #(
    .DIV(QUARTER_CYC_P)
  ) tw_tick_inst (
    .clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .clr_i(idle_w),
    .tick_o(tick_w)
  );

  // data line comes from a pin, so it is synchronised first
  tw_sync2 #(
    .RST_VAL(PIN_HIGH_RST)
  ) tw_sync2_inst (
    .clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .async_i(slave_data_line_i),
    .sync_o(sda_s)
  );

  // ================================================================
  // byte put on the bus for each segment
  function automatic logic [7:0] byte_of(input tw_seg_e seg, input logic [7:0] regb,
                                         input logic [7:0] wdb);
    logic [7:0] b;
    b = RX_FILL;
    case (seg)
      SEG_ADDR_W: b = {DEV_ADDR, DIR_WRITE};
      SEG_REG: b = regb;
      SEG_WDATA: b = wdb;
      SEG_ADDR_R: b = {DEV_ADDR, DIR_READ};
      default: b = RX_FILL;
    endcase
    return b;
  endfunction : byte_of

  // ================================================================
  // bus engine next state
  always_comb
  begin
    state_nxt = state_r;
    seg_nxt = seg_r;
    phase_nxt = phase_r;
    bitcnt_nxt = bitcnt_r;
    shift_nxt = shift_r;
    rw_nxt = rw_r;
    reg_nxt = reg_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    nack_nxt = nack_r;
    fault_nxt = fault_r;
    sample_nxt = sample_r;
    done_nxt = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        // take a command, every transfer opens with a start
        if (cmd_valid_i)
        begin
          rw_nxt = cmd_read_i;
          reg_nxt = cmd_reg_i;
          wdata_nxt = cmd_wdata_i;
          nack_nxt = 1'b0;
          fault_nxt = 1'b0;
          seg_nxt = SEG_ADDR_W;
          phase_nxt = PH_FIRST;
          state_nxt = ST_START;
        end
      end
      ST_START:
      begin
        if (tick_w)
        begin
          if (phase_r == PH_COND_LAST)
          begin
            state_nxt = ST_BIT;
            phase_nxt = PH_FIRST;
            bitcnt_nxt = '0;
            shift_nxt = byte_of(seg_r, reg_r, wdata_r);
          end
          else
          begin
            phase_nxt = phase_r + 3'h1;
          end
        end
      end
      ST_BIT:
      begin
        if (tick_w)
        begin
          phase_nxt = phase_r + 3'h1;
          // sample in the middle of clock high
          if (phase_r == PH_SAMPLE)
          begin
            sample_nxt = sda_s;
            if (data_bit)
            begin
              shift_nxt = {shift_r[6:0], sda_s};
            end
            else if (is_tx && sda_s)
            begin
              nack_nxt = 1'b1;
            end
            if (data_bit && is_tx && !sda_oe_r && !sda_s)
            begin
              fault_nxt = 1'b1;
            end
          end
          // end of the bit at the falling edge
          if (phase_r == PH_BIT_LAST)
          begin
            phase_nxt = PH_FIRST;
            if (data_bit && !line_moved)
            begin
              bitcnt_nxt = bitcnt_r + 4'h1;
            end
            else if (byte_abort)
            begin
              fault_nxt = fault_r || line_moved;
              state_nxt = ST_STOP;
            end
            else
            begin
              bitcnt_nxt = '0;
              case (seg_r)
                SEG_ADDR_W:
                begin
                  seg_nxt = SEG_REG;
                end
                SEG_REG:
                begin
                  if (rw_r == DIR_READ)
                  begin
                    seg_nxt = SEG_ADDR_R;
                    state_nxt = ST_START;
                  end
                  else
                  begin
                    seg_nxt = SEG_WDATA;
                  end
                end
                SEG_ADDR_R:
                begin
                  seg_nxt = SEG_RDATA;
                end
                SEG_RDATA:
                begin
                  rdata_nxt = shift_r;
                  state_nxt = ST_STOP;
                end
                default:
                begin
                  state_nxt = ST_STOP;
                end
              endcase
              shift_nxt = byte_of(seg_nxt, reg_r, wdata_r);
            end
          end
        end
      end
      ST_STOP:
      begin
        if (tick_w)
        begin
          if (phase_r == PH_COND_LAST)
          begin
            state_nxt = ST_FREE;
            phase_nxt = PH_FIRST;
          end
          else
          begin
            phase_nxt = phase_r + 3'h1;
          end
        end
      end
      ST_FREE:
      begin
        // hold both lines high for the bus free time
        if (tick_w)
        begin
          if (phase_r == PH_FREE_LAST)
          begin
            state_nxt = ST_IDLE;
            phase_nxt = PH_FIRST;
            done_nxt = 1'b1;
          end
          else
          begin
            phase_nxt = phase_r + 3'h1;
          end
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
        phase_nxt = PH_FIRST;
      end
    endcase
  end

  // ================================================================
  // pin levels from the coming phase
  always_comb
  begin
    // clock low for quarters 0-1, high for 2 onward; high when free
    scl_nxt = lines_free || (phase_nxt >= PH_SCL_HIGH);
    sda_oe_nxt = sda_oe_r;
    case (state_nxt)
      ST_START:
      begin
        sda_oe_nxt = (phase_nxt >= PH_COND_SDA);
      end
      ST_STOP:
      begin
        sda_oe_nxt = (phase_nxt < PH_COND_SDA);
      end
      ST_BIT:
      begin
        // change data one quarter after the falling edge
        if (state_r == ST_BIT && tick_w && phase_r == PH_FIRST)
        begin
          sda_oe_nxt = drive_low_w;
        end
      end
      default:
      begin
        sda_oe_nxt = 1'b0;
      end
    endcase
    ready_nxt = (state_nxt == ST_IDLE);
  end

  // ================================================================
  // engine registers
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      state_r <= ST_IDLE;
      seg_r <= SEG_ADDR_W;
      phase_r <= PH_FIRST;
      bitcnt_r <= '0;
      shift_r <= BYTE_RST;
      rw_r <= DIR_WRITE;
      reg_r <= BYTE_RST;
      wdata_r <= BYTE_RST;
    end
    else
    begin
      state_r <= state_nxt;
      seg_r <= seg_nxt;
      phase_r <= phase_nxt;
      bitcnt_r <= bitcnt_nxt;
      shift_r <= shift_nxt;
      rw_r <= rw_nxt;
      reg_r <= reg_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // ================================================================
  // result and pin registers
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      rdata_r <= BYTE_RST;
      nack_r <= 1'b0;
      fault_r <= 1'b0;
      sample_r <= PIN_HIGH_RST;
      done_r <= 1'b0;
      ready_r <= 1'b1;
      scl_r <= PIN_HIGH_RST;
      sda_oe_r <= 1'b0;
      sda_lvl_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      nack_r <= nack_nxt;
      fault_r <= fault_nxt;
      sample_r <= sample_nxt;
      done_r <= done_nxt;
      ready_r <= ready_nxt;
      scl_r <= scl_nxt;
      sda_oe_r <= sda_oe_nxt;
      sda_lvl_r <= 1'b0; // only ever pulls low
    end
  end

  // ================================================================
  // outputs
  assign cmd_ready_o = ready_r;
  assign done_o = done_r;
  assign nack_o = nack_r;
  assign fault_o = fault_r;
  assign rdata_o = rdata_r;
  assign scl_o = scl_r;
  assign slave_data_line_o = sda_lvl_r;
  assign slave_data_line_oe_o = sda_oe_r;

endmodule : tw_master
`default_nettype wire

// ===== test/tw_master_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// protocol checker on the host pins
module tw_master_chk
#(
  parameter int QUARTER_CYC_P = 63
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // command side
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire logic done_o,
  input wire logic nack_o,
  input wire logic [7:0] rdata_o,
  // pins
  input wire logic scl_o,
  input wire logic slave_data_line_oe_o
);
  localparam int STOP_LO = 4 * QUARTER_CYC_P - 4;
  localparam int STOP_HI = 4 * QUARTER_CYC_P + 4;
  localparam int HALF_MIN = 2 * QUARTER_CYC_P - 2;
  logic [11:0] lo_r, hi_r, lo_nxt, hi_nxt;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // saturating run lengths of each clock level
  assign lo_nxt = scl_o ? 12'h000 : lo_r + {11'h000, lo_r != 12'hFFF};
  assign hi_nxt = !scl_o ? 12'h000 : hi_r + {11'h000, hi_r != 12'hFFF};
  always_ff @(posedge sys_clk_i)
  begin
    lo_r <= rst_b_i ? lo_nxt : 12'h000;
    hi_r <= rst_b_i ? hi_nxt : 12'h000;
  end
  // ================================================================
  // assertions
  property p_idle_lines;
    cmd_ready_o |-> scl_o && !slave_data_line_oe_o;
  endproperty
  a_idle_lines: assert property (p_idle_lines) else $error("bus not idle while ready");
  property p_take;
    cmd_valid_i && cmd_ready_o |=> (!cmd_ready_o && !slave_data_line_oe_o) [*8];
  endproperty
  a_take: assert property (p_take) else $error("take did not start cleanly");
  property p_done_ready;
    $rose(cmd_ready_o) |-> done_o;
  endproperty
  a_done_ready: assert property (p_done_ready) else $error("ready without done");
  property p_stop_done;
    $fell(slave_data_line_oe_o) && scl_o |-> ##[STOP_LO:STOP_HI] done_o;
  endproperty
  a_stop_done: assert property (p_stop_done) else $error("no done after stop");
  property p_oe_high;
    $changed(slave_data_line_oe_o) && scl_o |-> $past(scl_o, QUARTER_CYC_P);
  endproperty
  a_oe_high: assert property (p_oe_high) else $error("data moved early in clock high");
  property p_scl_low;
    $rose(scl_o) |-> lo_r >= HALF_MIN;
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("clock low too short");
  property p_scl_high;
    $fell(scl_o) && !$past(cmd_ready_o) |-> hi_r >= HALF_MIN;
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high too short");
  property p_nack_hold;
    $changed(nack_o) |-> !cmd_ready_o;
  endproperty
  a_nack_hold: assert property (p_nack_hold) else $error("nack moved while idle");
  property p_rdata_hold;
    $changed(rdata_o) |-> !cmd_ready_o;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved while idle");
  // main scenarios
  c_ack_done: cover property (done_o && !nack_o);
  c_nack_done: cover property (done_o && nack_o);
  c_read_byte: cover property ($changed(rdata_o));
endmodule : tw_master_chk

bind tw_master tw_master_chk #(.QUARTER_CYC_P(QUARTER_CYC_P)) tw_master_chk_inst (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid_i),
  .cmd_ready_o(cmd_ready_o), .done_o(done_o), .nack_o(nack_o), .rdata_o(rdata_o),
  .scl_o(scl_o), .slave_data_line_oe_o(slave_data_line_oe_o));
`default_nettype wire

// ===== test/tw_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// behavioural sensor slave on the two-wire pins
module tw_dev_model
(
  // pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  // device controls
  input wire logic async_reset_n_i,
  input wire logic sleep_i,
  input wire logic [6:0] own_addr_i
);
  typedef enum logic [2:0] {DV_IDLE, DV_ADDR, DV_REG, DV_WDATA, DV_READ} tw_dev_e;
  logic [7:0] regs [256];
  logic [7:0] shift_r, ptr_r, tx_r;
  logic [3:0] bits_r;
  tw_dev_e st_r;
  wire logic awake = async_reset_n_i && !sleep_i;
  // clear all registers while reset is low
  task automatic clear_all();
    for (int i = 0; i < 256; i++)
      regs[i] = 8'h00;
    st_r = DV_IDLE;
    bits_r = 4'h0;
    ptr_r = 8'h00;
    sda_oe_o = 1'h0;
  endtask : clear_all
  initial clear_all();
  always @(negedge async_reset_n_i) clear_all();
  // start restarts address reception
  always @(negedge sda_i)
    if (scl_i && awake)
    begin
      st_r = DV_ADDR;
      bits_r = 4'h0;
    end
  // stop drops the transfer, part bytes are lost
  always @(posedge sda_i)
    if (scl_i)
      st_r = DV_IDLE;
  // bits sampled on the rising clock
  always @(posedge scl_i)
    if (awake && st_r != DV_IDLE)
    begin
      if (bits_r == 4'h8)
      begin
        bits_r = 4'h0;
        if (st_r == DV_READ && sda_i)
          st_r = DV_IDLE;
      end
      else
      begin
        shift_r = {shift_r[6:0], sda_i};
        bits_r = bits_r + 4'h1;
      end
    end
  // answers change only after the falling clock
  always @(negedge scl_i)
    if (awake)
    begin
      sda_oe_o = 1'h0;
      if (bits_r == 4'h8)
      begin
        case (st_r)
          DV_ADDR:
            if (shift_r[7:1] == own_addr_i)
            begin
              sda_oe_o = 1'h1;
              tx_r = regs[ptr_r];
              st_r = shift_r[0] ? DV_READ : DV_REG;
            end
            else
              st_r = DV_IDLE;
          DV_REG:
          begin
            sda_oe_o = 1'h1;
            ptr_r = shift_r;
            st_r = DV_WDATA;
          end
          DV_WDATA:
          begin
            sda_oe_o = 1'h1;
            regs[ptr_r] = shift_r;
          end
          default: sda_oe_o = 1'h0;
        endcase
      end
      else if (st_r == DV_READ)
        sda_oe_o = !tx_r[3'h7 - bits_r[2:0]];
    end
endmodule : tw_dev_model
`default_nettype wire

// ===== test/tw_master_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// bench: host against the sensor model
module tw_master_bench;
  localparam int QC = 8;
  logic sys_clk_i, rst_b_i, cmd_valid_i, cmd_read_i, dev_rst_n, jam, dev_sleep;
  logic [7:0] cmd_reg_i, cmd_wdata_i, rdata_o;
  logic [6:0] dev_addr;
  logic cmd_ready_o, done_o, nack_o, fault_o, scl_o, sda_o, m_oe, s_oe;
  wire logic sda_w;
  int err_total, samples_checked, cyc;
  // pull-up resolves the shared data line, jam is a stuck-low third party
  assign sda_w = !(m_oe || s_oe || jam);
  tw_master #(.QUARTER_CYC_P(QC)) tw_master_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .cmd_valid_i(cmd_valid_i), .cmd_read_i(cmd_read_i), .cmd_reg_i(cmd_reg_i),
    .cmd_wdata_i(cmd_wdata_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o), .nack_o(nack_o),
    .fault_o(fault_o), .rdata_o(rdata_o), .scl_o(scl_o), .slave_data_line_i(sda_w),
    .slave_data_line_o(sda_o), .slave_data_line_oe_o(m_oe));
  tw_dev_model tw_dev_model_inst (.scl_i(scl_o), .sda_i(sda_w), .sda_oe_o(s_oe),
    .async_reset_n_i(dev_rst_n), .sleep_i(dev_sleep), .own_addr_i(dev_addr));
  initial
  begin
    sys_clk_i = 1'h0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // ================================================================
  // helpers
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk_span(input int got, input int exp);
    samples_checked++;
    if (got < exp - 4 || got > exp + 4)
    begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_span
  // one command, cycles from take to done left in cyc
  task automatic run_cmd(input logic rd, input logic [7:0] rg, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'h1;
    cmd_read_i <= rd;
    cmd_reg_i <= rg;
    cmd_wdata_i <= wd;
    do
    begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    while (cmd_ready_o !== 1'h0 && n < 10);
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'h0;
    cyc = 1;
    do
    begin
      @(posedge sys_clk_i);
      #1;
      cyc++;
    end
    while (done_o !== 1'h1 && cyc < 2000);
    if (n >= 10 || cyc >= 2000)
    begin
      err_total++;
      close_out();
    end
  endtask : run_cmd
  // ================================================================
  // scenarios
  task automatic t_reset();
    chk8({cmd_ready_o, done_o, nack_o, fault_o, scl_o, m_oe, sda_o, sda_w}, 8'h89);
    chk8(rdata_o, 8'h00);
  endtask : t_reset
  task automatic t_write_read();
    logic [7:0] rg [3] = '{8'h00, 8'h7F, 8'hFF};
    logic [7:0] wd [3] = '{8'hC6, 8'h01, 8'h80};
    for (int i = 0; i < 3; i++)
    begin
      run_cmd(1'h0, rg[i], wd[i]);
      chk_span(cyc, 122 * QC);
      chk8({7'h00, nack_o}, 8'h00);
      chk8(tw_dev_model_inst.regs[rg[i]], wd[i]);
    end
    for (int i = 0; i < 3; i++)
    begin
      run_cmd(1'h1, rg[i], 8'h00);
      chk_span(cyc, 164 * QC);
      chk8(rdata_o, wd[i]);
      chk8({6'h00, nack_o, fault_o}, 8'h00);
    end
  endtask : t_write_read
  task automatic t_mismatch();
    @(posedge sys_clk_i);
    dev_addr <= 7'h75;
    run_cmd(1'h0, 8'h10, 8'h3A);
    chk8({7'h00, nack_o}, 8'h01);
    chk8({7'h00, cyc < 60 * QC}, 8'h01);
    chk8(tw_dev_model_inst.regs[8'h10], 8'h00);
    chk8({7'h00, scl_o & sda_w}, 8'h01);
    dev_addr <= tw_pkg::DEV_ADDR;
    run_cmd(1'h1, 8'h10, 8'h00);
    chk8({7'h00, nack_o}, 8'h00);
    chk8(rdata_o, 8'h00);
    // stuck-low line: released one bits read back low, transfer cut short
    @(posedge sys_clk_i);
    jam <= 1'h1;
    run_cmd(1'h0, 8'h20, 8'h55);
    chk8({6'h00, nack_o, fault_o}, 8'h01);
    chk8({7'h00, cyc < 60 * QC}, 8'h01);
    chk8(tw_dev_model_inst.regs[8'h20], 8'h00);
    @(posedge sys_clk_i);
    jam <= 1'h0;
  endtask : t_mismatch
  task automatic t_dev_reset();
    @(posedge sys_clk_i);
    dev_rst_n <= 1'h0;
    repeat (3) @(posedge sys_clk_i);
    dev_rst_n <= 1'h1;
    dev_sleep <= 1'h1;
    // a sleeping sensor does not answer and keeps its registers
    run_cmd(1'h0, 8'h7F, 8'h5A);
    chk8({7'h00, nack_o}, 8'h01);
    @(posedge sys_clk_i);
    dev_sleep <= 1'h0;
    run_cmd(1'h1, 8'h7F, 8'h00);
    chk8(rdata_o, 8'h00);
  endtask : t_dev_reset
  // ================================================================
  // main sequence
  initial
  begin
    err_total = 0;
    samples_checked = 0;
    rst_b_i = 1'h0;
    cmd_valid_i = 1'h0;
    cmd_read_i = 1'h0;
    cmd_reg_i = 8'h00;
    cmd_wdata_i = 8'h00;
    dev_rst_n = 1'h0;
    jam = 1'h0;
    dev_sleep = 1'h0;
    dev_addr = tw_pkg::DEV_ADDR;
    repeat (12) @(posedge sys_clk_i);
    rst_b_i <= 1'h1;
    dev_rst_n <= 1'h1;
    @(posedge sys_clk_i);
    #1;
    t_reset();
    t_write_read();
    t_mismatch();
    t_dev_reset();
    close_out();
  end
endmodule : tw_master_bench
`default_nettype wire
